// [hw/cpusr_core.sv]
// Purpose: dedicated cpu registers, status word and bank addressing
// Assumes: software drives operations through the register port
// Notes: read data appear one cycle after the read strobe
module cpusr_core
    import cpusr_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [1:0] IRQ_LEVEL,
    input wire logic IRQ_REQ,
    output logic [15:0] RDATA,
    output logic [15:0] GR_ADDR,
    output logic IRQ_TAKE,
    output logic [15:0] IP_OUT
);
    // ****************************************
    // state
    // ****************************************
    logic [15:0] instruction_pointer;
    logic [15:0] acc;
    logic [15:0] tmp_acc;
    logic [15:0] index_register;
    logic [15:0] extra_pointer;
    logic [15:0] stack_pointer;
    logic [7:0] bank_pointer;
    logic [7:0] condition_codes;
    logic [2:0] op_code_low;
    logic [2:0] op_sel;
    logic [15:0] last_result;
    cpusr_state_t state;
    logic irq_req_s1;
    logic irq_req_s2;
    logic [1:0] irq_lvl_s1;
    logic [1:0] irq_lvl_s2;
    cpusr_alu_if alu_bus();

    cpusr_alu u_alu (
        .alu(alu_bus)
    );

    // ****************************************
    // decode
    // ****************************************
    wire wr_ip = WR && (ADDR == CPUSR_REG_IP);
    wire wr_acc = WR && (ADDR == CPUSR_REG_ACC);
    wire wr_tmp = WR && (ADDR == CPUSR_REG_TMP);
    wire wr_ix = WR && (ADDR == CPUSR_REG_IX);
    wire wr_xp = WR && (ADDR == CPUSR_REG_XP);
    wire wr_stk = WR && (ADDR == CPUSR_REG_STK);
    wire wr_psw = WR && (ADDR == CPUSR_REG_PSW);
    wire wr_op = WR && (ADDR == CPUSR_REG_OP);
    wire [15:0] program_status_word = {bank_pointer, condition_codes};
    wire exec = state == CPUSR_ST_EXEC;
    wire is_shift = (op_sel == CPUSR_OP_SHL) || (op_sel == CPUSR_OP_SHR);
    wire is_word_op = (op_sel == CPUSR_OP_ADDW) || (op_sel == CPUSR_OP_SUBW);

    assign alu_bus.op = op_sel;
    assign alu_bus.a = acc;
    assign alu_bus.b = tmp_acc;
    assign alu_bus.carry_in = condition_codes[CPUSR_CC_C];

    // general register address: fixed high pattern, bank, opcode bits
    wire [15:0] next_gr_addr = {7'h00, CPUSR_GR_HIGH[0], bank_pointer[4:0], op_code_low};

    // level 0 highest, 3 lowest; request must be strictly higher priority
    wire [1:0] cur_level = {condition_codes[CPUSR_CC_IL1], condition_codes[CPUSR_CC_IL0]};
    wire level_ok = irq_lvl_s2 < cur_level;
    wire next_irq_take = irq_req_s2 && condition_codes[CPUSR_CC_I] && level_ok;

    // new condition codes after an operation
    wire [7:0] cc_after_op = {
        (is_shift ? condition_codes[CPUSR_CC_H] : alu_bus.flag_h),
        condition_codes[CPUSR_CC_I],
        condition_codes[CPUSR_CC_IL1],
        condition_codes[CPUSR_CC_IL0],
        alu_bus.flag_n,
        alu_bus.flag_z,
        (is_shift ? condition_codes[CPUSR_CC_V] : alu_bus.flag_v),
        alu_bus.flag_c
    };
    wire [15:0] acc_after_op = is_word_op ? alu_bus.result : {acc[15:8], alu_bus.result[7:0]};

    // ****************************************
    // read mux
    // ****************************************
    logic [15:0] next_rdata;
    always_comb begin
        case (ADDR)
            CPUSR_REG_IP: next_rdata = instruction_pointer;
            CPUSR_REG_ACC: next_rdata = acc;
            CPUSR_REG_TMP: next_rdata = tmp_acc;
            CPUSR_REG_IX: next_rdata = index_register;
            CPUSR_REG_XP: next_rdata = extra_pointer;
            CPUSR_REG_STK: next_rdata = stack_pointer;
            CPUSR_REG_PSW: next_rdata = program_status_word;
            CPUSR_REG_OP: next_rdata = {10'h000, op_sel, op_code_low};
            CPUSR_REG_RES: next_rdata = last_result;
            CPUSR_REG_GRA: next_rdata = next_gr_addr;
            CPUSR_REG_IRQ: next_rdata = {13'h0000, next_irq_take, irq_lvl_s2};
            default: next_rdata = 16'h0000;
        endcase
    end

    // ****************************************
    // synchronisers for pin inputs
    // ****************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            irq_req_s1 <= 1'b0;
            irq_req_s2 <= 1'b0;
            irq_lvl_s1 <= 2'h3;
            irq_lvl_s2 <= 2'h3;
        end else begin
            irq_req_s1 <= IRQ_REQ;
            irq_req_s2 <= irq_req_s1;
            irq_lvl_s1 <= IRQ_LEVEL;
            irq_lvl_s2 <= irq_lvl_s1;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state <= CPUSR_ST_IDLE;
        end else begin
            case (state)
                CPUSR_ST_IDLE: state <= (wr_op && (WDATA[5:3] != CPUSR_OP_NONE)) ? CPUSR_ST_EXEC : CPUSR_ST_IDLE;
                CPUSR_ST_EXEC: state <= CPUSR_ST_IDLE;
                default: state <= CPUSR_ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // dedicated registers
    // ****************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            instruction_pointer <= CPUSR_RST_WORD;
            index_register <= CPUSR_RST_WORD;
            extra_pointer <= CPUSR_RST_WORD;
            stack_pointer <= CPUSR_RST_WORD;
            tmp_acc <= CPUSR_RST_WORD;
        end else begin
            if (wr_ip) begin
                instruction_pointer <= WDATA;
            end else if (exec) begin
                instruction_pointer <= instruction_pointer + 16'h0001;
            end
            if (wr_ix) index_register <= WDATA;
            if (wr_xp) extra_pointer <= WDATA;
            if (wr_stk) stack_pointer <= WDATA;
            if (wr_tmp) tmp_acc <= WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            acc <= CPUSR_RST_WORD;
            last_result <= CPUSR_RST_WORD;
        end else if (exec) begin
            acc <= acc_after_op;
            last_result <= alu_bus.result;
        end else if (wr_acc) begin
            acc <= WDATA;
        end
    end

    // operation result wins over a status write to the condition codes in the same cycle; the bank pointer still takes the write
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            bank_pointer <= CPUSR_RST_PSW[15:8];
            condition_codes <= CPUSR_RST_PSW[7:0];
        end else begin
            if (wr_psw) bank_pointer <= WDATA[15:8];
            if (exec) begin
                condition_codes <= cc_after_op;
            end else if (wr_psw) begin
                condition_codes <= WDATA[7:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            op_sel <= CPUSR_OP_NONE;
            op_code_low <= 3'h0;
        end else if (wr_op) begin
            op_sel <= WDATA[5:3];
            op_code_low <= WDATA[2:0];
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
            GR_ADDR <= 16'h0100;
            IRQ_TAKE <= 1'b0;
            IP_OUT <= CPUSR_RST_WORD;
        end else begin
            RDATA <= RD ? next_rdata : 16'h0000;
            GR_ADDR <= next_gr_addr;
            IRQ_TAKE <= next_irq_take;
            IP_OUT <= instruction_pointer;
        end
    end
endmodule // cpusr_core

// [hw/cpusr_pkg.sv]
// Purpose: constants for the cpu status and register bank block
// Assumes: 25 MHz core clock, 16-bit dedicated registers
// Notes: register indices are word offsets on the plain register port
package cpusr_pkg;
    // ****************************************
    // register indices
    // ****************************************
    localparam logic [3:0] CPUSR_REG_IP = 4'h0;
    localparam logic [3:0] CPUSR_REG_ACC = 4'h1;
    localparam logic [3:0] CPUSR_REG_TMP = 4'h2;
    localparam logic [3:0] CPUSR_REG_IX = 4'h3;
    localparam logic [3:0] CPUSR_REG_XP = 4'h4;
    localparam logic [3:0] CPUSR_REG_STK = 4'h5;
    localparam logic [3:0] CPUSR_REG_PSW = 4'h6;
    localparam logic [3:0] CPUSR_REG_OP = 4'h7;
    localparam logic [3:0] CPUSR_REG_RES = 4'h8;
    localparam logic [3:0] CPUSR_REG_GRA = 4'h9;
    localparam logic [3:0] CPUSR_REG_IRQ = 4'ha;
    // ****************************************
    // condition code bit positions
    // ****************************************
    localparam int CPUSR_CC_H = 7;
    localparam int CPUSR_CC_I = 6;
    localparam int CPUSR_CC_IL1 = 5;
    localparam int CPUSR_CC_IL0 = 4;
    localparam int CPUSR_CC_N = 3;
    localparam int CPUSR_CC_Z = 2;
    localparam int CPUSR_CC_V = 1;
    localparam int CPUSR_CC_C = 0;
    // ****************************************
    // reset values and address pattern
    // ****************************************
    localparam logic [15:0] CPUSR_RST_WORD = 16'h0000;
    localparam logic [15:0] CPUSR_RST_PSW = 16'h0030;
    localparam logic [2:0] CPUSR_GR_HIGH = 3'h1;
    // ****************************************
    // operations
    // ****************************************
    typedef enum logic [2:0] {
        CPUSR_OP_NONE = 3'h0,
        CPUSR_OP_ADD = 3'h1,
        CPUSR_OP_SUB = 3'h2,
        CPUSR_OP_SHL = 3'h3,
        CPUSR_OP_SHR = 3'h4,
        CPUSR_OP_ADDW = 3'h5,
        CPUSR_OP_SUBW = 3'h6
    } cpusr_op_t;
    typedef enum logic [1:0] {
        CPUSR_ST_IDLE = 2'b01,
        CPUSR_ST_EXEC = 2'b10
    } cpusr_state_t;
endpackage

// [hw/cpusr_alu_if.sv]
// Purpose: carries operands and flag results between core and alu
// Assumes: same clock on both ends
// Notes: combinational path only
interface cpusr_alu_if;
    logic [2:0] op;
    logic [15:0] a;
    logic [15:0] b;
    logic carry_in;
    logic [15:0] result;
    logic flag_h;
    logic flag_n;
    logic flag_z;
    logic flag_v;
    logic flag_c;
    modport core (output op, output a, output b, output carry_in,
        input result, input flag_h, input flag_n, input flag_z, input flag_v, input flag_c);
    modport alu (input op, input a, input b, input carry_in,
        output result, output flag_h, output flag_n, output flag_z, output flag_v, output flag_c);
endinterface

// [hw/cpusr_alu.sv]
// Purpose: arithmetic and condition flags for 8 and 16 bit data
// Assumes: byte operations use only the low bytes
// Notes: purely combinational
module cpusr_alu
    import cpusr_pkg::*;
(
    cpusr_alu_if.alu alu
);
    // ****************************************
    // byte and word arithmetic
    // ****************************************
    wire [7:0] a8 = alu.a[7:0];
    wire [7:0] b8 = alu.b[7:0];
    wire is_sub = (alu.op == CPUSR_OP_SUB) || (alu.op == CPUSR_OP_SUBW);
    wire is_word = (alu.op == CPUSR_OP_ADDW) || (alu.op == CPUSR_OP_SUBW);
    wire [4:0] lo_add = {1'b0, a8[3:0]} + {1'b0, b8[3:0]};
    wire [4:0] lo_sub = {1'b0, a8[3:0]} - {1'b0, b8[3:0]};
    wire [8:0] byte_add = {1'b0, a8} + {1'b0, b8};
    wire [8:0] byte_sub = {1'b0, a8} - {1'b0, b8};
    wire [16:0] word_add = {1'b0, alu.a} + {1'b0, alu.b};
    wire [16:0] word_sub = {1'b0, alu.a} - {1'b0, alu.b};
    wire [8:0] byte_res = is_sub ? byte_sub : byte_add;
    wire [16:0] word_res = is_sub ? word_sub : word_add;
    wire is_shl = alu.op == CPUSR_OP_SHL;
    wire is_shr = alu.op == CPUSR_OP_SHR;
    wire [7:0] shl_res = {a8[6:0], alu.carry_in};
    wire [7:0] shr_res = {alu.carry_in, a8[7:1]};
    wire [7:0] res8 = is_shl ? shl_res : (is_shr ? shr_res : byte_res[7:0]);
    wire sa = is_word ? alu.a[15] : a8[7];
    wire sb = is_word ? alu.b[15] : b8[7];
    wire sr = is_word ? word_res[15] : byte_res[7];
    assign alu.result = is_word ? word_res[15:0] : {8'h00, res8};
    assign alu.flag_h = is_sub ? lo_sub[4] : lo_add[4];
    assign alu.flag_n = is_word ? word_res[15] : res8[7];
    assign alu.flag_z = is_word ? (word_res[15:0] == 16'h0000) : (res8 == 8'h00);
    assign alu.flag_v = is_sub ? ((sa != sb) && (sr != sa)) : ((sa == sb) && (sr != sa));
    assign alu.flag_c = is_shl ? a8[7] : (is_shr ? a8[0] : (is_word ? word_res[16] : byte_res[8]));
endmodule // cpusr_alu

// [verification/cpusr_core_chk.sv]
// Purpose: port-level checks for cpusr_core
// Assumes: one clock, synchronous active-low reset
// Notes: attached by the bind below the module
module cpusr_core_chk
    import cpusr_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [1:0] IRQ_LEVEL,
    input wire logic IRQ_REQ,
    input wire logic [15:0] RDATA,
    input wire logic [15:0] GR_ADDR,
    input wire logic IRQ_TAKE,
    input wire logic [15:0] IP_OUT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    wire logic op_wr = WR && ADDR == CPUSR_REG_OP;
    wire logic psw_wr = WR && ADDR == CPUSR_REG_PSW;
    wire logic ip_wr = WR && ADDR == CPUSR_REG_IP;
    wire logic [4:0] wr_bank = WDATA[12:8];
    wire logic [2:0] wr_opc = WDATA[2:0];
    chk_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
        else $error("read data not cleared");
    chk_gr_high: assert property (GR_ADDR[15:8] == 8'h01)
        else $error("general register high pattern wrong");
    chk_gr_bank: assert property (psw_wr ##1 !psw_wr |=> GR_ADDR[7:3] == $past(wr_bank, 2))
        else $error("bank bits not in general register address");
    chk_gr_opcode: assert property (op_wr ##1 !op_wr |=> GR_ADDR[2:0] == $past(wr_opc, 2))
        else $error("opcode bits not in general register address");
    chk_take_req: assert property (IRQ_TAKE |-> $past(IRQ_REQ, 3))
        else $error("take without request");
    chk_take_level: assert property (IRQ_TAKE |-> $past(IRQ_LEVEL, 3) != 2'h3)
        else $error("lowest level request taken");
    chk_take_reset: assert property ($rose(RST_N) |-> (!IRQ_TAKE) [*2])
        else $error("take right after reset");
    chk_ip_step: assert property (op_wr && WDATA[5:3] != 3'h0 ##1 !ip_wr |-> ##2 IP_OUT == $past(IP_OUT) + 16'h0001)
        else $error("pointer not advanced by one");
    chk_ip_hold: assert property ((!(ip_wr || op_wr)) [*3] |=> $stable(IP_OUT))
        else $error("pointer moved without cause");
endmodule // cpusr_core_chk

bind cpusr_core cpusr_core_chk i_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .IRQ_LEVEL(IRQ_LEVEL), .IRQ_REQ(IRQ_REQ), .RDATA(RDATA), .GR_ADDR(GR_ADDR),
    .IRQ_TAKE(IRQ_TAKE), .IP_OUT(IP_OUT));

// [verification/cpusr_core_tb.sv]
// Purpose: self-checking bench for cpusr_core
// Assumes: 25 MHz clock, register port with read data one cycle later
// Notes: interrupt pins are swept through every level and enable
module cpusr_core_tb
    import cpusr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {cpusr_op_t op; logic [15:0] a; logic [15:0] b; logic [15:0] r; logic [7:0] cc;} cpusr_vec_t;
    logic CORE_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [1:0] IRQ_LEVEL = 2'h0;
    logic IRQ_REQ = 1'b0;
    logic [15:0] RDATA;
    logic [15:0] GR_ADDR;
    logic IRQ_TAKE;
    logic [15:0] IP_OUT;
    int error_cnt = 0;
    int checks_done = 0;
    cpusr_vec_t vec [8] = '{
        '{CPUSR_OP_ADD, 16'h120f, 16'hff01, 16'h1210, 8'h80},
        '{CPUSR_OP_ADD, 16'h007f, 16'h0001, 16'h0080, 8'h8a},
        '{CPUSR_OP_ADD, 16'h00ff, 16'h0001, 16'h0000, 8'h85},
        '{CPUSR_OP_SUB, 16'h3405, 16'h0005, 16'h3400, 8'h04},
        '{CPUSR_OP_SHL, 16'h0081, 16'h0000, 16'h0002, 8'h01},
        '{CPUSR_OP_SHR, 16'h5601, 16'h0000, 16'h5600, 8'h05},
        '{CPUSR_OP_ADDW, 16'h7fff, 16'h0001, 16'h8000, 8'h8a},
        '{CPUSR_OP_SUBW, 16'h1234, 16'h1234, 16'h0000, 8'h04}};
    cpusr_core i_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .IRQ_LEVEL(IRQ_LEVEL), .IRQ_REQ(IRQ_REQ), .RDATA(RDATA), .GR_ADDR(GR_ADDR), .IRQ_TAKE(IRQ_TAKE),
        .IP_OUT(IP_OUT));
    initial begin
        forever #20 CORE_CLK = ~CORE_CLK;
    end
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CORE_CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CORE_CLK);
        WR <= 1'b0;
    endtask
    task automatic rc(input string what, input logic [3:0] a, input logic [15:0] exp);
        @(posedge CORE_CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CORE_CLK);
        RD <= 1'b0;
        #1;
        chk(what, RDATA, exp);
    endtask
    task automatic tk(input logic e);
        repeat (4) @(posedge CORE_CLK);
        #1;
        chk("take", {15'h0000, IRQ_TAKE}, {15'h0000, e});
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100us;
        error_cnt++;
        stop_test();
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        rc("psw", CPUSR_REG_PSW, CPUSR_RST_PSW);
        rc("ip", CPUSR_REG_IP, 16'h0000);
        chk("gr_addr", GR_ADDR, 16'h0100);
        for (int i = 0; i < 6; i++) begin
            wr(i[3:0], {i[3:0], 12'ha5c});
            rc("reg", i[3:0], {i[3:0], 12'ha5c});
        end
        wr(4'hc, 16'hffff);
        rc("unmapped", 4'hc, 16'h0000);
        wr(CPUSR_REG_PSW, 16'h1f00);
        wr(CPUSR_REG_OP, 16'h0005);
        rc("psw", CPUSR_REG_PSW, 16'h1f00);
        chk("gr_addr", GR_ADDR, 16'h01fd);
        rc("gra", CPUSR_REG_GRA, 16'h01fd);
        wr(CPUSR_REG_IP, 16'hfffc);
        foreach (vec[i]) begin
            wr(CPUSR_REG_PSW, 16'h0000);
            wr(CPUSR_REG_ACC, vec[i].a);
            wr(CPUSR_REG_TMP, vec[i].b);
            wr(CPUSR_REG_OP, {10'h000, vec[i].op, 3'h0});
            rc("acc", CPUSR_REG_ACC, vec[i].r);
            rc("flags", CPUSR_REG_PSW, {8'h00, vec[i].cc});
            rc("result", CPUSR_REG_RES, (vec[i].op >= CPUSR_OP_ADDW) ? vec[i].r : {8'h00, vec[i].r[7:0]});
        end
        rc("ip", CPUSR_REG_IP, 16'h0004);
        @(posedge CORE_CLK);
        IRQ_REQ <= 1'b1;
        for (int ie = 0; ie < 2; ie++) begin
            for (int il = 0; il < 4; il++) begin
                for (int lv = 0; lv < 4; lv++) begin
                    wr(CPUSR_REG_PSW, {9'h000, ie[0], il[1:0], 4'h0});
                    IRQ_LEVEL <= lv[1:0];
                    tk(ie == 1 && lv < il);
                end
            end
        end
        @(posedge CORE_CLK);
        IRQ_LEVEL <= 2'h0;
        tk(1'b1);
        rc("irq", CPUSR_REG_IRQ, 16'h0004);
        @(posedge CORE_CLK);
        IRQ_REQ <= 1'b0;
        tk(1'b0);
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        rc("psw", CPUSR_REG_PSW, CPUSR_RST_PSW);
        stop_test();
    end
endmodule // cpusr_core_tb
